// file: core/dual_timer_event_counter.sv
// Purpose: Two count-up timer/event counters, 8-bit and 16-bit, on APB.
// Assumes: Pins and sub clock asynchronous; sampled through synchronisers.
// Notes:   Zero-wait APB slave; unmapped addresses answer pslverr.
//
// What this block does
// [R1] One 8-bit and one 16-bit counter, each with three modes.
// [R2] Control bits 7 and 6 hold each timer's mode field.
// [R3] Mode bits 1,0 select interval timing.
// [R4] Control bit 4 is run: high counts, low halts.
// [R5] Timer 0 bits 2..0 pick prescale ratio; unused for pin clocking.
// [R6] Bit 3 picks active pin edge in event and pulse modes.
// [R7] Timer 1 clock: sub clock or system/4, by option and select bit.
// [R8] Event mode advances by one per selected pin transition.
// [R9] Interval mode advances by one per internal tick while running.
// [R10] Past full count: interrupt request, reload preload, keep counting.
// [R11] Preload write while stopped loads counter; while running, at overflow.
// [R12] Timer 1 low write buffers; high write moves both bytes together.
// [R13] Timer 1 high read latches low byte; low read returns latch.
// [R14] Software writes low then high; reads high then low.
// [R15] Count register read returns the live counter contents.
// [R16] Overflow request passes only when its enable bit is set.
// [R17] Event mode: edge bit low counts rising, high counts falling.
// [R18] Mode bits 0,1 select event counting.
// [R19] Mode bits 1,1 select pulse width; counting starts at active edge.
// [R20] Pulse end clears run itself; later edges ignored until rerun.
// [R21] Interrupt is one-cycle pulse; pin edges synchronised first.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module dual_timer_event_counter
  import timer_pkg::*;
#(
  parameter int PRESCALE_STAGES = 7,
  parameter bit TIMER1_SUB_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins and slow clock
  input wire logic timer0_input_pin,
  input wire logic timer1_input_pin,
  input wire logic sub_clock,
  // Overflow interrupt requests
  output logic timer0_irq,
  output logic timer1_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  generate
    if (PRESCALE_STAGES < 1 || PRESCALE_STAGES > 7) begin : g_bad_psc
      $error("PRESCALE_STAGES must lie between 1 and 7");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Decoding functions

  // Mode field to mode; the unused code stops the counter
  function automatic mode_t decode_mode(input logic [7:0] ctrl);
    case (ctrl[MODE_HI:MODE_LO])
      MODE_CODE_TIMER: decode_mode = MODE_TIMER; // R3
      MODE_CODE_EVENT: decode_mode = MODE_EVENT; // R18
      MODE_CODE_PULSE: decode_mode = MODE_PULSE; // R19
      default: decode_mode = MODE_OFF;
    endcase
  endfunction

  // Whether a counter advances this cycle
  function automatic logic advance(input mode_t mode, input logic run,
                                   input logic tick, input logic ev_edge,
                                   input logic measuring);
    case (mode)
      MODE_TIMER: advance = run & tick; // R9
      MODE_EVENT: advance = run & ev_edge; // R8
      MODE_PULSE: advance = run & measuring & tick; // R19
      default: advance = 1'b0;
    endcase
  endfunction

  // Prescaler tick: divide by two to the power of the ratio field
  function automatic logic psc_tick(input logic [6:0] cnt,
                                    input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'h00;
    for (int i = 0; i < PRESCALE_STAGES; i++) begin
      if (i < int'(sel)) begin
        mask[i] = 1'b1;
      end
    end
    psc_tick = ((cnt & mask) == mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: timer 0 pin, timer 1 pin, sub clock
  logic [2:0] raw_pin;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  assign raw_pin = {sub_clock, timer1_input_pin, timer0_input_pin};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      pin_edge_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(raw_pin[g]),
        .level(),
        .rise(pin_rise[g]),
        .fall(pin_fall[g])
      ); // R21
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] t0_ctrl;
  logic [7:0] t1_ctrl;
  logic [7:0] int_ctrl;
  logic [7:0] t0_count;
  logic [7:0] t0_preload;
  logic [15:0] t1_count;
  logic [15:0] t1_preload;
  logic [7:0] t1_low_wbuf;
  logic [7:0] t1_low_rbuf;
  logic [6:0] psc_count;
  logic [1:0] div4_count;
  pulse_state_t t0_pw;
  pulse_state_t t1_pw;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic setup;
  logic access;
  logic [7:0] wbyte;
  logic wr_t0_count;
  logic wr_t0_ctrl;
  logic wr_t1_low;
  logic wr_t1_high;
  logic wr_t1_ctrl;
  logic wr_int_ctrl;
  logic rd_t1_high;
  logic mapped;
  logic [31:0] rd_data;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wbyte = pwdata[7:0];
  assign wr_t0_count = access & pwrite & (paddr == ADDR_T0_COUNT);
  assign wr_t0_ctrl = access & pwrite & (paddr == ADDR_T0_CTRL);
  assign wr_t1_low = access & pwrite & (paddr == ADDR_T1_LOW);
  assign wr_t1_high = access & pwrite & (paddr == ADDR_T1_HIGH);
  assign wr_t1_ctrl = access & pwrite & (paddr == ADDR_T1_CTRL);
  assign wr_int_ctrl = access & pwrite & (paddr == ADDR_INT_CTRL);
  // Latch happens with the data capture so both bytes match
  assign rd_t1_high = setup & ~pwrite & (paddr == ADDR_T1_HIGH);

  // Read mux; narrow registers sit in the low byte
  always_comb begin
    mapped = 1'b1;
    rd_data = RDATA_ZERO;
    case (paddr)
      ADDR_T0_COUNT: rd_data[7:0] = t0_count; // R15
      ADDR_T0_CTRL: rd_data[7:0] = t0_ctrl;
      ADDR_T1_LOW: rd_data[7:0] = t1_low_rbuf; // R13
      ADDR_T1_HIGH: rd_data[7:0] = t1_count[15:8]; // R15
      ADDR_T1_CTRL: rd_data[7:0] = t1_ctrl;
      ADDR_INT_CTRL: rd_data[7:0] = int_ctrl;
      default: mapped = 1'b0;
    endcase
  end

  // One wait-free access phase; answer prepared in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RDATA_ZERO;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal clock ticks
  mode_t t0_mode;
  mode_t t1_mode;
  logic t0_run;
  logic t1_run;
  logic t0_tick;
  logic t1_tick;
  logic div4_tick;

  assign t0_mode = decode_mode(t0_ctrl); // R2
  assign t1_mode = decode_mode(t1_ctrl); // R2
  assign t0_run = t0_ctrl[RUN_BIT]; // R4
  assign t1_run = t1_ctrl[RUN_BIT]; // R4
  // Prescaler feeds only the internal clock path
  assign t0_tick = psc_tick(psc_count, t0_ctrl[PSC_HI:PSC_LO]); // R5
  assign div4_tick = (div4_count == SYS_DIV4_LAST);
  // Sub clock is usable only when the build option allows it
  assign t1_tick = (TIMER1_SUB_OPTION && t1_ctrl[CLK_SEL_BIT]) ?
                   pin_rise[2] : div4_tick; // R7

  // Free-running dividers; ratio changes take effect on the fly
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      psc_count <= 7'h00;
      div4_count <= 2'h0;
    end else begin
      psc_count <= psc_count + 7'h01;
      div4_count <= div4_count + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge selection per timer
  logic t0_ev_edge;
  logic t1_ev_edge;
  logic t0_pw_start;
  logic t1_pw_start;
  logic t0_pw_end;
  logic t1_pw_end;

  // Event mode: low selects rising, high selects falling
  assign t0_ev_edge = t0_ctrl[EDGE_BIT] ? pin_fall[0] : pin_rise[0]; // R17
  assign t1_ev_edge = t1_ctrl[EDGE_BIT] ? pin_fall[1] : pin_rise[1]; // R17
  // Pulse mode: low measures a low pulse, high a high pulse
  assign t0_pw_start = t0_ctrl[EDGE_BIT] ? pin_rise[0] : pin_fall[0]; // R6
  assign t1_pw_start = t1_ctrl[EDGE_BIT] ? pin_rise[1] : pin_fall[1]; // R6
  assign t0_pw_end = t0_ctrl[EDGE_BIT] ? pin_fall[0] : pin_rise[0];
  assign t1_pw_end = t1_ctrl[EDGE_BIT] ? pin_fall[1] : pin_rise[1];

  ////////////////////////////////////////////////////////////////////////
  // Pulse width sequencers
  logic t0_pw_done;
  logic t1_pw_done;

  assign t0_pw_done = (t0_pw == PW_MEASURE) & t0_run & t0_pw_end;
  assign t1_pw_done = (t1_pw == PW_MEASURE) & t1_run & t1_pw_end;

  // Timer 0: wait for the active edge, measure until the return
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      t0_pw <= PW_WAIT;
    end else if (t0_mode != MODE_PULSE || !t0_run) begin
      t0_pw <= PW_WAIT;
    end else begin
      case (t0_pw)
        PW_WAIT: if (t0_pw_start) t0_pw <= PW_MEASURE; // R19
        PW_MEASURE: if (t0_pw_end) t0_pw <= PW_WAIT; // R20
        default: t0_pw <= PW_WAIT;
      endcase
    end
  end

  // Timer 1: same sequence
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      t1_pw <= PW_WAIT;
    end else if (t1_mode != MODE_PULSE || !t1_run) begin
      t1_pw <= PW_WAIT;
    end else begin
      case (t1_pw)
        PW_WAIT: if (t1_pw_start) t1_pw <= PW_MEASURE; // R19
        PW_MEASURE: if (t1_pw_end) t1_pw <= PW_WAIT; // R20
        default: t1_pw <= PW_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers; a software write wins over the auto clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      t0_ctrl <= CTRL_RESET;
    end else if (wr_t0_ctrl) begin
      t0_ctrl <= wbyte;
    end else if (t0_pw_done) begin
      t0_ctrl[RUN_BIT] <= 1'b0; // R20
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      t1_ctrl <= CTRL_RESET;
    end else if (wr_t1_ctrl) begin
      t1_ctrl <= wbyte;
    end else if (t1_pw_done) begin
      t1_ctrl[RUN_BIT] <= 1'b0; // R20
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_ctrl <= CTRL_RESET;
    end else if (wr_int_ctrl) begin
      int_ctrl <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters
  logic t0_adv;
  logic t1_adv;
  logic t0_ovf;
  logic t1_ovf;

  assign t0_adv = advance(t0_mode, t0_run, t0_tick, t0_ev_edge,
                          t0_pw == PW_MEASURE); // R1
  assign t1_adv = advance(t1_mode, t1_run, t1_tick, t1_ev_edge,
                          t1_pw == PW_MEASURE); // R1
  assign t0_ovf = t0_adv & (t0_count == T0_FULL);
  assign t1_ovf = t1_adv & (t1_count == T1_FULL);

  // Timer 0 count and preload; reset clears the preload to zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      t0_count <= BYTE_ZERO;
      t0_preload <= BYTE_ZERO;
    end else begin
      if (t0_ovf) begin
        t0_count <= t0_preload; // R10
      end else if (t0_adv) begin
        t0_count <= t0_count + 8'h01;
      end
      if (wr_t0_count) begin
        t0_preload <= wbyte;
        if (!t0_run) begin
          t0_count <= wbyte; // R11
        end
      end
    end
  end

  // Timer 1 count, preload and byte buffers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      t1_count <= WORD16_ZERO;
      t1_preload <= WORD16_ZERO;
      t1_low_wbuf <= BYTE_ZERO;
      t1_low_rbuf <= BYTE_ZERO;
    end else begin
      if (t1_ovf) begin
        t1_count <= t1_preload; // R10
      end else if (t1_adv) begin
        t1_count <= t1_count + 16'h0001;
      end
      if (wr_t1_low) begin
        t1_low_wbuf <= wbyte; // R12
      end
      if (wr_t1_high) begin
        t1_preload <= {wbyte, t1_low_wbuf}; // R12
        if (!t1_run) begin
          t1_count <= {wbyte, t1_low_wbuf}; // R11
        end
      end
      if (rd_t1_high) begin
        t1_low_rbuf <= t1_count[7:0]; // R13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests: one cycle per overflow, gated by enable
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      timer0_irq <= 1'b0;
      timer1_irq <= 1'b0;
    end else begin
      timer0_irq <= t0_ovf & int_ctrl[T0_IRQ_EN_BIT]; // R16
      timer1_irq <= t1_ovf & int_ctrl[T1_IRQ_EN_BIT]; // R21
    end
  end

endmodule

`default_nettype wire

// file: core/timer_pkg.sv
// Purpose: Shared constants and types for the dual timer/event counter.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes:   Control fields are laid out alike for both timers.
`default_nettype none

package timer_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_T0_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_T0_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_T1_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_T1_HIGH = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_T1_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = 8'h14;

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int CLK_SEL_BIT = 5;
  localparam int RUN_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int PSC_HI = 2;
  localparam int PSC_LO = 0;
  localparam logic [1:0] MODE_CODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_CODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_CODE_PULSE = 2'h3;

  // Interrupt control fields
  localparam int T0_IRQ_EN_BIT = 0;
  localparam int T1_IRQ_EN_BIT = 1;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD16_ZERO = 16'h0000;
  localparam logic [7:0] T0_FULL = 8'hff;
  localparam logic [15:0] T1_FULL = 16'hffff;
  localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_EVENT,
    MODE_TIMER,
    MODE_PULSE
  } mode_t;

  typedef enum logic {
    PW_WAIT,
    PW_MEASURE
  } pulse_state_t;

endpackage

`default_nettype wire

// file: core/pin_edge_sync.sv
// Purpose: Bring an asynchronous pin into the clock domain, find edges.
// Assumes: Pin changes slower than half the clock rate.
// Notes:   Edge pulses last one cycle, one to two cycles after the pin.
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Raw pin
  input wire logic pin_in,
  // Synchronised level and edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta;
  logic stable;
  logic prev;

  // Two-stage synchroniser plus one delay stage for edges
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_in;
      stable <= meta;
      prev <= stable;
    end
  end

  // Edges only look at settled stages, never the metastable one
  assign level = stable;
  assign rise = stable & ~prev;
  assign fall = ~stable & prev;

endmodule

`default_nettype wire

// file: bench/dual_timer_event_counter_chk.sv
// Purpose: Port-level checks of the dual timer block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Interrupt enables are mirrored from completed APB writes.
`timescale 1ns/100ps
`default_nettype none

module dual_timer_event_counter_chk
  import timer_pkg::*;
#(
  parameter int PRESCALE_STAGES = 7,
  parameter bit TIMER1_SUB_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic timer0_input_pin,
  input wire logic timer1_input_pin,
  input wire logic sub_clock,
  // Requests
  input wire logic timer0_irq,
  input wire logic timer1_irq
);
  logic [1:0] irq_en;
  logic mapped;

  ////////////////////////////////////////////////////////////////////////
  // Mirror of enables; one cycle of slack for a write racing an overflow
  assign mapped = paddr[1:0] == 2'h0 && paddr <= ADDR_INT_CTRL;
  always_ff @(posedge ref_clk) begin
    if (reset)
      irq_en <= 2'h0;
    else if (psel && penable && pready && pwrite && paddr == ADDR_INT_CTRL)
      irq_en <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_ready_after_setup;
    s_setup |=> s_access;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  property p_ready_single;
    pready |=> !pready;
  endproperty
  property p_err_unmapped;
    s_setup ##0 !mapped |=> pslverr && pready;
  endproperty
  property p_err_mapped;
    s_setup ##0 mapped |=> !pslverr;
  endproperty
  property p_rdata_unmapped;
    s_setup ##0 (!pwrite && !mapped) |=> prdata == RDATA_ZERO;
  endproperty
  property p_rdata_upper;
    prdata[31:8] == 24'h000000;
  endproperty
  property p_irq0_single;
    timer0_irq |=> !timer0_irq;
  endproperty
  property p_irq1_single;
    timer1_irq |=> !timer1_irq;
  endproperty
  property p_irq0_enabled;
    timer0_irq |-> irq_en[0] || $past(irq_en[0]);
  endproperty
  property p_irq1_enabled;
    timer1_irq |-> irq_en[1] || $past(irq_en[1]);
  endproperty

  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready after setup");
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("ready outside access");
  a_ready_single: assert property (p_ready_single)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (p_err_mapped)
    else $error("mapped access refused");
  a_rdata_unmapped: assert property (p_rdata_unmapped)
    else $error("unmapped read data not zero");
  a_rdata_upper: assert property (p_rdata_upper)
    else $error("read data upper bits set");
  a_irq0_single: assert property (p_irq0_single)
    else $error("timer 0 request too long");
  a_irq1_single: assert property (p_irq1_single)
    else $error("timer 1 request too long");
  a_irq0_enabled: assert property (p_irq0_enabled)
    else $error("timer 0 request while masked");
  a_irq1_enabled: assert property (p_irq1_enabled)
    else $error("timer 1 request while masked");
endmodule

bind dual_timer_event_counter dual_timer_event_counter_chk #(
  .PRESCALE_STAGES(PRESCALE_STAGES),
  .TIMER1_SUB_OPTION(TIMER1_SUB_OPTION)
) u_chk (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer0_input_pin(timer0_input_pin),
  .timer1_input_pin(timer1_input_pin), .sub_clock(sub_clock),
  .timer0_irq(timer0_irq), .timer1_irq(timer1_irq)
);

`default_nettype wire

// file: bench/timer_pin_source.sv
// Purpose: External pulse source on a timer input pin.
// Assumes: Driven from the bench clock, idle low after start.
// Notes:   Each level lasts gap cycles; callers keep gap at two or more.
`timescale 1ns/100ps
`default_nettype none

module timer_pin_source (
  // Clock
  input wire logic ref_clk,
  // Driven pin
  output logic pin
);
  initial pin = 1'b0;

  // Levels held long enough for the synchroniser to see them
  task automatic toggle(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge ref_clk);
      pin <= ~pin;
    end
  endtask
endmodule

`default_nettype wire

// file: bench/dual_timer_event_counter_tb.sv
// Purpose: Self-checking bench for the dual timer block.
// Assumes: Zero-wait APB slave, default prescale depth.
// Notes:   Interrupt spacing gives exact tick rates.
`timescale 1ns/100ps
`default_nettype none

module dual_timer_event_counter_tb
  import timer_pkg::*;
;
  logic ref_clk, reset, psel, penable, pwrite, sub_clock, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, pin0, pin1, timer0_irq, timer1_irq;
  logic [1:0] irqs;
  logic [7:0] rd, lo, p;
  logic [31:0] seed = 32'h04d5;
  int error_cnt = 0;
  int comparisons = 0;
  int irq_n[2] = '{0, 0};
  longint last_t[2] = '{0, 0};
  longint gap_c[2] = '{0, 0};
  int k;
  logic [15:0] cnt, cnt2;

  dual_timer_event_counter #(.PRESCALE_STAGES(7), .TIMER1_SUB_OPTION(1'b1))
  u_dual_timer_event_counter (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_input_pin(pin0),
    .timer1_input_pin(pin1), .sub_clock(sub_clock),
    .timer0_irq(timer0_irq), .timer1_irq(timer1_irq));
  timer_pin_source u_pin_src0 (.ref_clk(ref_clk), .pin(pin0));
  timer_pin_source u_pin_src1 (.ref_clk(ref_clk), .pin(pin1));

  ////////////////////////////////////////////////////////////////////////
  // Clocks; sub clock of eight cycles, fixed phase offset
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    sub_clock = 1'b0;
    #3;
    forever #40 sub_clock = ~sub_clock;
  end

  // Request spacing in cycles
  assign irqs = {timer1_irq, timer0_irq};
  always @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (irqs[i] === 1'b1) begin
        irq_n[i]++;
        gap_c[i] = ($time - last_t[i]) / 10;
        last_t[i] = $time;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; refusal expected off the word map
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    check(16'(err), 16'(a[1:0] != 2'h0 || a > ADDR_INT_CTRL));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Count read, high byte first for the wide timer
  task automatic rdcnt(input int t, output logic [15:0] v);
    if (t == 0) begin
      apb(1'b0, ADDR_T0_COUNT, 8'h00);
      v = {8'h00, rd};
    end else begin
      apb(1'b0, ADDR_T1_HIGH, 8'h00);
      v = {rd, 8'h00};
      apb(1'b0, ADDR_T1_LOW, 8'h00);
      v[7:0] = rd;
    end
  endtask

  task automatic preload(input int t, input logic [15:0] v);
    if (t == 0) begin
      apb(1'b1, ADDR_T0_COUNT, v[7:0]);
    end else begin
      apb(1'b1, ADDR_T1_LOW, v[7:0]);
      apb(1'b1, ADDR_T1_HIGH, v[15:8]);
    end
  endtask

  task automatic wait_irq(input int t, input int exp);
    int n0;
    n0 = irq_n[t];
    for (int i = 0; i < 3 * exp + 60 && irq_n[t] < n0 + 2; i++)
      @(posedge ref_clk);
    check(16'(gap_c[t]), 16'(exp));
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #600000;
    error_cnt++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // Reset values, one unmapped read and write
    for (int a = 0; a < 8'h1c; a += 4) begin
      apb(1'b0, 8'(a), 8'h00);
      check(16'(rd), 16'h0000);
    end
    apb(1'b1, 8'h18, 8'hff);
    // Mode field codes read back
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ADDR_T0_CTRL, {2'(m), 6'h08});
      apb(1'b0, ADDR_T0_CTRL, 8'h00);
      check(16'(rd), 16'({2'(m), 6'h08}));
    end
    apb(1'b1, ADDR_T0_CTRL, CTRL_RESET);
    // Stopped preload loads the counter; wide timer byte order
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      preload(0, seed[15:0]);
      rdcnt(0, cnt);
      check(16'(cnt), 16'(seed[7:0]));
      preload(1, seed[23:8]);
      rdcnt(1, cnt);
      check(16'(cnt), seed[23:8]);
    end
    // Interval timer 0 over every prescale ratio
    apb(1'b1, ADDR_INT_CTRL, 8'h03);
    for (int n = 0; n < 8; n++) begin
      seed = xs(seed);
      p = 8'he0 | seed[4:0];
      if (p == 8'hff)
        p = 8'hfe;
      preload(0, 16'(p));
      apb(1'b1, ADDR_T0_CTRL, {MODE_CODE_TIMER, 3'b010, 3'(n)});
      wait_irq(0, (256 - p) << n);
      apb(1'b1, ADDR_T0_CTRL, CTRL_RESET);
    end
    // Timer 1 from sub clock, then from system clock over four
    preload(1, 16'hfff0);
    apb(1'b1, ADDR_T1_CTRL, {MODE_CODE_TIMER, 6'h30});
    wait_irq(1, 128);
    apb(1'b1, ADDR_T1_CTRL, {MODE_CODE_TIMER, 6'h10});
    wait_irq(1, 64);
    // Latched low byte stays while counting
    apb(1'b0, ADDR_T1_HIGH, 8'h00);
    apb(1'b0, ADDR_T1_LOW, 8'h00);
    lo = rd;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, ADDR_T1_LOW, 8'h00);
    check(16'(rd), 16'(lo));
    apb(1'b1, ADDR_T1_CTRL, CTRL_RESET);
    // Masked overflow gives no request
    apb(1'b1, ADDR_INT_CTRL, 8'h00);
    k = irq_n[0];
    preload(0, 16'h00f0);
    apb(1'b1, ADDR_T0_CTRL, {MODE_CODE_TIMER, 6'h10});
    repeat (100) @(posedge ref_clk);
    check(16'(irq_n[0]), 16'(k));
    apb(1'b1, ADDR_T0_CTRL, CTRL_RESET);
    // Event counting, both timers, both edges; pin returned low after each run
    for (int t = 0; t < 2; t++) begin
      for (int e = 0; e < 2; e++) begin
        seed = xs(seed);
        k = 3 + seed[1:0];
        preload(t, 16'h0000);
        apb(1'b1, t ? ADDR_T1_CTRL : ADDR_T0_CTRL, {MODE_CODE_EVENT, 2'b01,
          1'(e), 3'b000});
        if (t == 0)
          u_pin_src0.toggle(2 * k + 1, 4);
        else
          u_pin_src1.toggle(2 * k + 1, 4);
        repeat (10) @(posedge ref_clk);
        rdcnt(t, cnt);
        check(16'(cnt), 16'(e ? k : k + 1));
        apb(1'b1, t ? ADDR_T1_CTRL : ADDR_T0_CTRL, CTRL_RESET);
        if (t == 0)
          u_pin_src0.toggle(1, 4);
        else
          u_pin_src1.toggle(1, 4);
      end
    end
    // Pulse width: timer 1 high pulse, timer 0 low pulse
    preload(1, 16'h0000);
    apb(1'b1, ADDR_T1_CTRL, {MODE_CODE_PULSE, 6'h18});
    u_pin_src1.toggle(1, 4);
    u_pin_src1.toggle(1, 40);
    repeat (10) @(posedge ref_clk);
    rdcnt(1, cnt);
    check(cnt, 16'h000a);
    preload(0, 16'h0000);
    u_pin_src0.toggle(1, 4);
    apb(1'b1, ADDR_T0_CTRL, {MODE_CODE_PULSE, 6'h10});
    repeat (20) @(posedge ref_clk);
    rdcnt(0, cnt);
    check(16'(cnt), 16'h0000);
    u_pin_src0.toggle(1, 4);
    u_pin_src0.toggle(1, 40);
    repeat (10) @(posedge ref_clk);
    rdcnt(0, cnt);
    check(16'(cnt >= 39 && cnt <= 41), 16'h0001);
    apb(1'b0, ADDR_T0_CTRL, 8'h00);
    check(16'(rd[RUN_BIT]), 16'h0000);
    u_pin_src0.toggle(2, 6);
    repeat (10) @(posedge ref_clk);
    rdcnt(0, cnt2);
    check(cnt2, cnt);
    close_out();
  end
endmodule

`default_nettype wire
